/* segment_bar_graph_driver.sv */
// segment bar graph driver: ahb-lite registers, weight scaling and segment drive
// Contract
// - drive forty-eight individually switched bar segments
// - step mode: active batch step lights three segments
// - step mode: continuous non-batch setpoints stay lit
// - graph mode: empty at start, full at setpoint
// - band equal setpoint: segment about two percent
// - band mode below low: only leftmost lit
// - band mode from low: fill left to right
// - band mode at midpoint: all segments lit
// - band mode past midpoint: extinguish from left
// - band mode above high: only rightmost lit
// - bar follows its own selected channel
//
// The AHB-Lite slave port and the address map are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module segment_bar_graph_driver (
  // clock and reset
  input  wire logic                                  hclk,
  input  wire logic                                  hresetn,
  // ahb-lite slave
  input  wire logic                                  hsel,
  input  wire logic [31:0]                           haddr,
  input  wire logic [1:0]                            htrans,
  input  wire logic                                  hwrite,
  input  wire logic [2:0]                            hsize,
  input  wire logic [31:0]                           hwdata,
  input  wire logic                                  hready,
  output logic                                       hreadyout,
  output logic                                       hresp,
  output logic      [31:0]                           hrdata,
  // weight samples
  input  wire logic                                  weight_valid,
  input  wire logic [bar_graph_pkg::CHAN_W-1:0]      weight_chan,
  input  wire logic [bar_graph_pkg::WEIGHT_W-1:0]    weight_value,
  // batch status
  input  wire logic [bar_graph_pkg::STEP_GROUPS-1:0] step_active,
  // display
  output logic      [bar_graph_pkg::SEG_COUNT-1:0]   seg_out
);
  import bar_graph_pkg::*;

  // lowest q segments lit, counting from the left end
  function automatic logic [SEG_COUNT-1:0] fill_left(input logic [5:0] q);
    logic [SEG_COUNT:0] ones;
    ones = ({{SEG_COUNT{1'b0}}, 1'b1} << q) - 49'h1;
    fill_left = (q >= SEG_FULL) ? {SEG_COUNT{1'b1}} : ones[SEG_COUNT-1:0];
  endfunction

  // each setpoint owns three adjacent segments
  function automatic logic [SEG_COUNT-1:0] expand_groups(input logic [STEP_GROUPS-1:0] m);
    logic [SEG_COUNT-1:0] v;
    v = '0;
    for (int i = 0; i < STEP_GROUPS; i++) begin
      v[3*i +: 3] = {3{m[i]}};
    end
    expand_groups = v;
  endfunction

  function automatic logic [NUM_W-1:0] times48(input logic [WEIGHT_W-1:0] x);
    logic [NUM_W-1:0] w;
    w = {{(NUM_W-WEIGHT_W){1'b0}}, x};
    times48 = (w << 5) + (w << 4);
  endfunction

  // ---------------- register bus ----------------
  logic                    wr_pend_reg;
  logic [7:0]              wr_addr_reg;
  logic [1:0]              mode_reg;
  logic [CHAN_W-1:0]       chan_reg;
  logic [WEIGHT_W-1:0]     setpoint_reg;
  logic [WEIGHT_W-1:0]     band_reg;
  logic [WEIGHT_W-1:0]     low_reg;
  logic [WEIGHT_W-1:0]     high_reg;
  logic [31:0]             stepcfg_reg;
  logic [5:0]              count_reg;
  logic [WEIGHT_W-1:0]     weight_reg;
  state_type               state_reg;
  logic                    accept;
  logic [31:0]             rd_next;

  assign accept = hsel && htrans[1] && hready;

  always_comb begin
    rd_next = 32'h00000000;
    unique case (haddr[7:0])
      CTRL_OFS:     rd_next = {26'h0, chan_reg, 2'h0, mode_reg};
      SETPOINT_OFS: rd_next = {8'h00, setpoint_reg};
      BAND_OFS:     rd_next = {8'h00, band_reg};
      LOW_OFS:      rd_next = {8'h00, low_reg};
      HIGH_OFS:     rd_next = {8'h00, high_reg};
      STEPCFG_OFS:  rd_next = stepcfg_reg;
      STATUS_OFS:   rd_next = {2'h0, count_reg, weight_reg};
      SEGLO_OFS:    rd_next = seg_out[31:0];
      SEGHI_OFS:    rd_next = {16'h0000, seg_out[SEG_COUNT-1:32]};
      default:      rd_next = 32'h00000000;
    endcase
    if (haddr[31:8] != 24'h000000) begin
      rd_next = 32'h00000000;
    end
  end

  // zero wait states; unmapped reads give zero and writes are dropped
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout   <= 1'b1;
      hresp       <= 1'b0;
      hrdata      <= 32'h00000000;
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
    end else begin
      hreadyout   <= 1'b1;
      hresp       <= 1'b0;
      wr_pend_reg <= accept && hwrite && (haddr[31:8] == 24'h000000);
      if (accept) begin
        wr_addr_reg <= haddr[7:0];
        if (!hwrite) begin
          hrdata <= rd_next;
        end
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode_reg     <= MODE_OFF;
      chan_reg     <= '0;
      setpoint_reg <= SETPOINT_RST;
      band_reg     <= BAND_RST;
      low_reg      <= LOW_RST;
      high_reg     <= HIGH_RST;
      stepcfg_reg  <= STEPCFG_RST;
    end else if (wr_pend_reg) begin
      unique case (wr_addr_reg)
        CTRL_OFS: begin
          mode_reg <= hwdata[CTRL_MODE_LSB +: 2];
          chan_reg <= hwdata[CTRL_CHAN_LSB +: CHAN_W];
        end
        SETPOINT_OFS: setpoint_reg <= hwdata[WEIGHT_W-1:0];
        BAND_OFS:     band_reg     <= hwdata[WEIGHT_W-1:0];
        LOW_OFS:      low_reg      <= hwdata[WEIGHT_W-1:0];
        HIGH_OFS:     high_reg     <= hwdata[WEIGHT_W-1:0];
        STEPCFG_OFS:  stepcfg_reg  <= hwdata;
        default: ;
      endcase
    end
  end

  // ---------------- weight scaling ----------------
  logic [WEIGHT_W-1:0] lower;
  logic [WEIGHT_W-1:0] mid;
  logic                div_start_reg;
  logic [NUM_W-1:0]    div_num_reg;
  logic [WEIGHT_W-1:0] div_den_reg;
  logic                div_done;
  logic [NUM_W-1:0]    div_quot;
  logic                right_reg;
  logic                sample_hit;

  assign lower      = (setpoint_reg > band_reg) ? setpoint_reg - band_reg : '0;
  assign mid        = low_reg + ((high_reg - low_reg) >> 1);
  assign sample_hit = weight_valid && (weight_chan == chan_reg);

  seg_divider u_div (
    .clk   (hclk),
    .rst_n (hresetn),
    .start (div_start_reg),
    .num   (div_num_reg),
    .den   (div_den_reg),
    .done  (div_done),
    .quot  (div_quot)
  );

  // a newer sample overrides one still in flight, so the bar always tracks the latest
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      weight_reg <= '0;
    end else if (sample_hit) begin
      weight_reg <= weight_value;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg     <= ST_IDLE;
      div_start_reg <= 1'b0;
      div_num_reg   <= '0;
      div_den_reg   <= '0;
      count_reg     <= 6'h00;
      right_reg     <= 1'b0;
    end else begin
      div_start_reg <= 1'b0;
      if (sample_hit) begin
        state_reg <= ST_CALC;
      end else begin
        unique case (state_reg)
          ST_IDLE: ;
          ST_CALC: begin
            state_reg <= ST_SHOW;
            right_reg <= 1'b0;
            if (mode_reg == MODE_GRAPH) begin
              if (weight_reg >= setpoint_reg) begin
                count_reg <= SEG_FULL;
              end else if (weight_reg <= lower) begin
                count_reg <= 6'h00;
              end else begin
                // linear map of lower..setpoint onto 0..48
                div_num_reg   <= times48(weight_reg - lower);
                div_den_reg   <= setpoint_reg - lower;
                div_start_reg <= 1'b1;
                state_reg     <= ST_DIV;
              end
            end else if (mode_reg == MODE_BAND) begin
              if (weight_reg < low_reg) begin
                count_reg <= 6'h01;
              end else if (weight_reg > high_reg) begin
                count_reg <= 6'h01;
                right_reg <= 1'b1;
              end else if (weight_reg <= mid) begin
                if (mid == low_reg) begin
                  count_reg <= SEG_FULL;
                end else begin
                  div_num_reg   <= times48(weight_reg - low_reg);
                  div_den_reg   <= mid - low_reg;
                  div_start_reg <= 1'b1;
                  state_reg     <= ST_DIV;
                end
              end else begin
                // lit part shrinks toward the right end
                div_num_reg   <= times48(high_reg - weight_reg);
                div_den_reg   <= high_reg - mid;
                div_start_reg <= 1'b1;
                right_reg     <= 1'b1;
                state_reg     <= ST_DIV;
              end
            end
          end
          ST_DIV: begin
            // a done pulse left over from an aborted run must not finish the new one
            if (div_done && !div_start_reg) begin
              count_reg <= (div_quot > {24'h0, SEG_FULL}) ? SEG_FULL : div_quot[5:0];
              state_reg <= ST_SHOW;
            end
          end
          ST_SHOW: state_reg <= ST_IDLE;
          default: state_reg <= ST_IDLE;
        endcase
      end
    end
  end

  // ---------------- segment drive ----------------
  logic [SEG_COUNT-1:0] batch_segs;
  logic [SEG_COUNT-1:0] cont_segs;

  assign batch_segs = expand_groups(stepcfg_reg[STEP_GROUPS-1:0] & step_active);
  assign cont_segs  = expand_groups(stepcfg_reg[STEP_CONT_LSB +: STEP_GROUPS]);

  // step mode follows the step inputs each cycle; the weight modes update on SHOW
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      seg_out <= '0;
    end else begin
      unique case (mode_reg)
        MODE_OFF:  seg_out <= '0;
        MODE_STEP: seg_out <= batch_segs | cont_segs;
        MODE_GRAPH, MODE_BAND: begin
          if (state_reg == ST_SHOW) begin
            seg_out <= right_reg ? ~fill_left(SEG_FULL - count_reg)
                                 : fill_left(count_reg);
          end
        end
      endcase
    end
  end

  // ---------------- checks ----------------
  step_batch_a: assert property (@(posedge hclk) disable iff (!hresetn)
    mode_reg == MODE_STEP && stepcfg_reg[1] && step_active[1] && !wr_pend_reg
    |=> seg_out[5:3] == 3'h7)
    else $error("active batch step group not lit");

  step_cont_a: assert property (@(posedge hclk) disable iff (!hresetn)
    mode_reg == MODE_STEP && !wr_pend_reg
    |=> (seg_out & $past(cont_segs)) == $past(cont_segs))
    else $error("continuous setpoint segments not steady");

  graph_full_a: assert property (@(posedge hclk) disable iff (!hresetn)
    state_reg == ST_CALC && !sample_hit && mode_reg == MODE_GRAPH
    && weight_reg >= setpoint_reg && !wr_pend_reg
    |=> ##1 seg_out == {SEG_COUNT{1'b1}})
    else $error("bar not full at setpoint");

  graph_empty_a: assert property (@(posedge hclk) disable iff (!hresetn)
    state_reg == ST_CALC && !sample_hit && mode_reg == MODE_GRAPH
    && weight_reg <= lower && weight_reg < setpoint_reg && !wr_pend_reg
    |=> ##1 seg_out == '0)
    else $error("bar not empty at fill start");

  band_under_a: assert property (@(posedge hclk) disable iff (!hresetn)
    state_reg == ST_CALC && !sample_hit && mode_reg == MODE_BAND
    && weight_reg < low_reg && !wr_pend_reg
    |=> ##1 seg_out == 48'h000000000001)
    else $error("under band must show leftmost only");

  band_over_a: assert property (@(posedge hclk) disable iff (!hresetn)
    state_reg == ST_CALC && !sample_hit && mode_reg == MODE_BAND
    && weight_reg > high_reg && !wr_pend_reg
    |=> ##1 seg_out == 48'h800000000000)
    else $error("over band must show rightmost only");

  band_mid_a: assert property (@(posedge hclk) disable iff (!hresetn)
    state_reg == ST_SHOW && mode_reg == MODE_BAND && !sample_hit && !right_reg
    && weight_reg == mid && high_reg > low_reg
    |=> seg_out == {SEG_COUNT{1'b1}})
    else $error("band midpoint must light all");

  count_range_a: assert property (@(posedge hclk) disable iff (!hresetn)
    count_reg <= SEG_FULL)
    else $error("segment count beyond bar length");

  recompute_a: assert property (@(posedge hclk) disable iff (!hresetn)
    sample_hit && mode_reg != MODE_OFF && mode_reg != MODE_STEP
    |=> ##[0:34] (state_reg == ST_SHOW || sample_hit))
    else $error("sample not turned into a new bar");

  chan_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
    weight_valid && weight_chan != chan_reg |=> weight_reg == $past(weight_reg))
    else $error("unselected channel moved the bar weight");

  off_dark_a: assert property (@(posedge hclk) disable iff (!hresetn)
    mode_reg == MODE_OFF |=> seg_out == '0)
    else $error("bar not dark with the driver off");

  step_idle_a: assert property (@(posedge hclk) disable iff (!hresetn)
    mode_reg == MODE_STEP && stepcfg_reg[1] && !step_active[1]
    && !stepcfg_reg[STEP_CONT_LSB + 1]
    |=> seg_out[5:3] == 3'h0)
    else $error("inactive batch step group lit");

  band_right_a: assert property (@(posedge hclk) disable iff (!hresetn)
    state_reg == ST_SHOW && mode_reg == MODE_BAND && right_reg
    |=> seg_out[0] == (count_reg == SEG_FULL))
    else $error("upper half of band not lit from the right end");
endmodule // segment_bar_graph_driver
`default_nettype wire

/* bar_graph_pkg.sv */
// shared constants and types for the segment bar graph driver
package bar_graph_pkg;
  localparam int unsigned SEG_COUNT   = 48;
  localparam int unsigned STEP_GROUPS = 16;
  localparam int unsigned WEIGHT_W    = 24;
  localparam int unsigned NUM_W       = 30;
  localparam int unsigned CHAN_W      = 2;
  localparam logic [5:0]  SEG_FULL    = 6'h30;
  localparam logic [4:0]  DIV_STEPS   = 5'h1e;

  // register byte offsets
  localparam logic [7:0] CTRL_OFS     = 8'h00;
  localparam logic [7:0] SETPOINT_OFS = 8'h04;
  localparam logic [7:0] BAND_OFS     = 8'h08;
  localparam logic [7:0] LOW_OFS      = 8'h0c;
  localparam logic [7:0] HIGH_OFS     = 8'h10;
  localparam logic [7:0] STEPCFG_OFS  = 8'h14;
  localparam logic [7:0] STATUS_OFS   = 8'h18;
  localparam logic [7:0] SEGLO_OFS    = 8'h1c;
  localparam logic [7:0] SEGHI_OFS    = 8'h20;

  // field positions and reset values
  localparam int unsigned CTRL_MODE_LSB = 0;
  localparam int unsigned CTRL_CHAN_LSB = 4;
  localparam int unsigned STEP_CONT_LSB = 16;
  localparam logic [WEIGHT_W-1:0] SETPOINT_RST = 24'h000000;
  localparam logic [WEIGHT_W-1:0] BAND_RST     = 24'h000000;
  localparam logic [WEIGHT_W-1:0] LOW_RST      = 24'h000000;
  localparam logic [WEIGHT_W-1:0] HIGH_RST     = 24'h000000;
  localparam logic [31:0]         STEPCFG_RST  = 32'h00000000;

  typedef enum logic [1:0] {
    MODE_OFF   = 2'h0,
    MODE_STEP  = 2'h1,
    MODE_GRAPH = 2'h2,
    MODE_BAND  = 2'h3
  } mode_type;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_CALC = 4'h2,
    ST_DIV  = 4'h4,
    ST_SHOW = 4'h8
  } state_type;
endpackage

/* seg_divider.sv */
// sequential restoring divider for the weight-to-segment scaling
`timescale 1ns/1ps
`default_nettype none
module seg_divider (
  // clock and reset
  input  wire logic                                clk,
  input  wire logic                                rst_n,
  // request
  input  wire logic                                start,
  input  wire logic [bar_graph_pkg::NUM_W-1:0]     num,
  input  wire logic [bar_graph_pkg::WEIGHT_W-1:0]  den,
  // answer
  output logic                                     done,
  output logic      [bar_graph_pkg::NUM_W-1:0]     quot
);
  import bar_graph_pkg::*;

  logic [WEIGHT_W:0]   rem_reg;
  logic [NUM_W-1:0]    num_reg;
  logic [4:0]          cnt_reg;
  logic                busy_reg;
  logic [WEIGHT_W:0]   trial;
  logic [WEIGHT_W:0]   shifted;

  assign shifted = {rem_reg[WEIGHT_W-1:0], num_reg[NUM_W-1]};
  assign trial   = shifted - {1'b0, den};

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rem_reg  <= '0;
      num_reg  <= '0;
      quot     <= '0;
      cnt_reg  <= '0;
      busy_reg <= 1'b0;
      done     <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start) begin
        rem_reg  <= '0;
        num_reg  <= num;
        quot     <= '0;
        cnt_reg  <= DIV_STEPS;
        busy_reg <= 1'b1;
      end else if (busy_reg) begin
        // floor division, so a partial segment never lights
        num_reg <= {num_reg[NUM_W-2:0], 1'b0};
        if (!trial[WEIGHT_W]) begin
          rem_reg <= trial;
          quot    <= {quot[NUM_W-2:0], 1'b1};
        end else begin
          rem_reg <= shifted;
          quot    <= {quot[NUM_W-2:0], 1'b0};
        end
        cnt_reg <= cnt_reg - 5'h01;
        if (cnt_reg == 5'h01) begin
          busy_reg <= 1'b0;
          done     <= 1'b1;
        end
      end
    end
  end
endmodule // seg_divider
`default_nettype wire

/* led_bar_model.sv */
// behavioural model of the forty-eight segment led bar on the display board
`timescale 1ns/1ps
`default_nettype none
module led_bar_model (
  // segment drive from the driver
  input  wire logic [47:0] seg_drive,
  // what an observer of the bar would see
  output logic      [5:0]  lit_count,
  output logic             left_lit,
  output logic             right_lit
);
  // each segment is its own lamp, so the count is read lamp by lamp
  always_comb begin
    lit_count = 6'($countones(seg_drive));
  end

  // bit 0 sits at the left end of the bar, bit 47 at the right end
  assign left_lit  = seg_drive[0];
  assign right_lit = seg_drive[47];
endmodule // led_bar_model
`default_nettype wire

/* tb_segment_bar_graph_driver.sv */
// self-checking testbench for the segment bar graph driver
`timescale 1ns/1ps
`default_nettype none
module tb_segment_bar_graph_driver;
  import bar_graph_pkg::*;
  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic        hready;
  logic        hreadyout;
  logic        hresp;
  logic [31:0] hrdata;
  logic        weight_valid;
  logic [1:0]  weight_chan;
  logic [23:0] weight_value;
  logic [15:0] step_active;
  logic [47:0] seg_out;
  logic [5:0]  lit_count;
  logic        left_lit;
  logic        right_lit;
  int          fails;
  int          n_compared;

  assign hready = hreadyout;

  segment_bar_graph_driver dut_u (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .weight_valid(weight_valid), .weight_chan(weight_chan),
    .weight_value(weight_value), .step_active(step_active), .seg_out(seg_out)
  );

  led_bar_model bar_u (
    .seg_drive(seg_out), .lit_count(lit_count), .left_lit(left_lit),
    .right_lit(right_lit)
  );

  always #10 hclk = ~hclk;

  task automatic check(input string what, input logic [47:0] seen, input logic [47:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic end_of_test();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // one whole-word transfer; the slave never stalls but the wait is kept honest
  task automatic ahb_xfer(input logic [7:0] ofs, input logic wr, input logic [31:0] wd,
                          output logic [31:0] rd);
    hsel   <= 1'b1;
    haddr  <= {24'h000000, ofs};
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
    check("hresp", {47'h0, hresp}, 48'h0);
  endtask

  task automatic wr(input logic [7:0] ofs, input logic [31:0] d);
    logic [31:0] unused;
    ahb_xfer(ofs, 1'b1, d, unused);
  endtask

  task automatic check_reg(input string what, input logic [7:0] ofs, input logic [31:0] exp);
    logic [31:0] d;
    ahb_xfer(ofs, 1'b0, 32'h0, d);
    check(what, {16'h0000, d}, {16'h0000, exp});
  endtask

  // compares the pins, the lamp count and both segment registers
  task automatic check_bar(input logic [47:0] exp);
    check("seg_out", seg_out, exp);
    check("lit_count", {42'h0, lit_count}, 48'($countones(exp)));
    check_reg("seg_lo", SEGLO_OFS, exp[31:0]);
    check_reg("seg_hi", SEGHI_OFS, {16'h0000, exp[47:32]});
  endtask

  function automatic logic [47:0] fill_left(input int n);
    return (n >= 48) ? 48'hffffffffffff : ((48'h1 << n) - 48'h1);
  endfunction

  function automatic logic [47:0] fill_right(input int n);
    return ~fill_left(48 - n);
  endfunction

  function automatic logic [47:0] groups(input logic [15:0] m);
    logic [47:0] g;
    g = 48'h0;
    for (int i = 0; i < 16; i++) begin
      if (m[i]) begin
        g[3*i +: 3] = 3'h7;
      end
    end
    return g;
  endfunction

  // one sample then a wait past the longest divider run
  task automatic sample(input logic [1:0] ch, input logic [23:0] w, input logic [47:0] exp);
    weight_chan  <= ch;
    weight_value <= w;
    weight_valid <= 1'b1;
    @(posedge hclk);
    weight_valid <= 1'b0;
    repeat (50) @(posedge hclk);
    check_bar(exp);
  endtask

  task automatic test_reset();
    check("seg_reset", seg_out, 48'h0);
    for (int i = 0; i < 7; i++) begin
      check_reg("reg_reset", 8'(4 * i), 32'h0);
    end
    wr(8'h40, 32'h12345678);
    check_reg("unmapped", 8'h40, 32'h0);
    wr(STATUS_OFS, 32'hffffffff);
    check_reg("status_ro", STATUS_OFS, 32'h0);
    wr(CTRL_OFS, 32'hffffffff);
    check_reg("ctrl_fields", CTRL_OFS, 32'h00000033);
    wr(CTRL_OFS, 32'h0);
  endtask

  // batch steps 1 and 2, continuous setpoint 5
  task automatic test_step();
    logic [15:0] acts [5];
    acts = '{16'h0000, 16'h0004, 16'h0002, 16'h0008, 16'h0026};
    wr(STEPCFG_OFS, 32'h00200006);
    wr(CTRL_OFS, 32'h00000001);
    foreach (acts[i]) begin
      step_active <= acts[i];
      repeat (3) @(posedge hclk);
      check_bar(groups(acts[i] & 16'h0006) | groups(16'h0020));
    end
    step_active <= 16'h0;
  endtask

  task automatic test_graph();
    wr(SETPOINT_OFS, 32'd1000);
    wr(BAND_OFS, 32'd1000);
    wr(CTRL_OFS, 32'h00000022);
    sample(2'h2, 24'd0, fill_left(0));
    sample(2'h2, 24'd20, fill_left(0));
    sample(2'h2, 24'd21, fill_left(1));
    sample(2'h2, 24'd999, fill_left(47));
    sample(2'h2, 24'd1000, fill_left(48));
    sample(2'h2, 24'd500, fill_left(24));
    sample(2'h1, 24'd1000, fill_left(24));
    check_reg("status", STATUS_OFS, {2'h0, 6'd24, 24'd500});
    wr(BAND_OFS, 32'd400);
    sample(2'h2, 24'd800, fill_left(24));
    sample(2'h2, 24'd500, fill_left(0));
  endtask

  task automatic test_band();
    wr(LOW_OFS, 32'd100);
    wr(HIGH_OFS, 32'd300);
    wr(CTRL_OFS, 32'h00000003);
    sample(2'h0, 24'd50, 48'h000000000001);
    check("left_end", {47'h0, left_lit}, 48'h1);
    sample(2'h0, 24'd150, fill_left(24));
    sample(2'h0, 24'd200, fill_left(48));
    sample(2'h0, 24'd250, fill_right(24));
    sample(2'h0, 24'd275, fill_right(12));
    sample(2'h0, 24'd350, 48'h800000000000);
    check("right_end", {47'h0, right_lit}, 48'h1);
    wr(CTRL_OFS, 32'h00000000);
    repeat (2) @(posedge hclk);
    check_bar(48'h000000000000);
  endtask

  initial begin
    hclk         = 1'b0;
    hresetn      = 1'b0;
    hsel         = 1'b0;
    haddr        = 32'h0;
    htrans       = 2'h0;
    hwrite       = 1'b0;
    hsize        = 3'h2;
    hwdata       = 32'h0;
    weight_valid = 1'b0;
    weight_chan  = 2'h0;
    weight_value = 24'h0;
    step_active  = 16'h0;
    fails        = 0;
    n_compared   = 0;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    test_reset();
    test_step();
    test_graph();
    test_band();
    end_of_test();
  end

  // the whole run needs well under two thousand cycles
  initial begin
    repeat (20000) @(posedge hclk);
    fails++;
    $display("watchdog expired");
    end_of_test();
  end
endmodule // tb_segment_bar_graph_driver
`default_nettype wire
